// file: ret_pkg.sv
// package: encodings, widths and reset values for the return unit
package ret_pkg;
  localparam int          PC_W          = 16;   // program counter width
  localparam int          STK_DEPTH     = 16;   // return stack entries
  localparam int          SP_W          = 4;    // stack pointer width
  localparam logic [15:0] OPC_RETFI     = 16'h0005; // return from interrupt
  localparam logic [7:0]  OPC_RETLIT_HI = 8'hb6;    // return literal, high byte
  localparam logic [7:0]  WORK_RST      = 8'h00;
  localparam logic [7:0]  PCH_RST       = 8'h00;
  localparam logic [PC_W-1:0] PC_RST    = 16'h0000;
  localparam logic [SP_W-1:0] SP_RST    = 4'h0;
  localparam logic        GID_RST       = 1'b1;   // interrupts masked at reset
  localparam logic [PC_W-1:0] PC_STEP   = 16'h0001;
  localparam logic [SP_W-1:0] SP_STEP   = 4'h1;

  // execution phase: normal decode or forced no-operation
  typedef enum logic {PH_EXEC, PH_FNOP} phase_t;

  // decoding used by the top module and the assertions
  function automatic logic is_retfi(input logic [15:0] op);
    return op == OPC_RETFI;
  endfunction : is_retfi

  function automatic logic is_retlit(input logic [15:0] op);
    return op[15:8] == OPC_RETLIT_HI;
  endfunction : is_retlit
endpackage : ret_pkg

// file: ret_stack.sv
// module: hardware return stack, registered top-of-stack read
`timescale 1ns/1ps
module ret_stack (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // stack port
  stack_if.stack    sp
);
  logic [ret_pkg::PC_W-1:0] mem_q [ret_pkg::STK_DEPTH]; // entries
  logic [ret_pkg::SP_W-1:0] ptr_q, ptr_d;               // next free slot
  logic [ret_pkg::PC_W-1:0] top_q, top_d;               // registered top

  // next pointer and top value; the pointer wraps like a ring
  always_comb begin
    ptr_d = ptr_q;
    top_d = top_q;
    if (sp.push) begin
      ptr_d = ptr_q + ret_pkg::SP_STEP;
      top_d = sp.push_data;
    end else if (sp.pop) begin
      ptr_d = ptr_q - ret_pkg::SP_STEP;
      top_d = mem_q[ptr_q - ret_pkg::SP_STEP - ret_pkg::SP_STEP];
    end
  end

  // entries hold no reset; only the pointer and top do
  always_ff @(posedge clk) begin
    if (sp.push) begin
      mem_q[ptr_q] <= sp.push_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr_q <= ret_pkg::SP_RST;
      top_q <= ret_pkg::PC_RST;
    end else begin
      ptr_q <= ptr_d;
      top_q <= top_d;
    end
  end

  assign sp.top   = top_q;
  assign sp.depth = ptr_q;
endmodule : ret_stack

// file: return_instruction_exec.sv
// module: execution of the two return instructions of the 8-bit core
// Functional notes
// - interrupt return: pc from stack, pop, enable interrupts
// - literal return writes literal to working register
// - literal return: pc from stack, pop entry
// - literal return keeps pc high latch unchanged
`timescale 1ns/1ps
module return_instruction_exec (
  // clock and reset
  input  wire logic                       clock_in,
  input  wire logic                       rstn_in,
  // instruction stream from fetch
  input  wire logic                       instr_valid_in,
  input  wire logic [15:0]                instr_in,
  // call and pc high latch write from the rest of the core
  input  wire logic                       call_in,
  input  wire logic [ret_pkg::PC_W-1:0]   call_addr_in,
  input  wire logic                       pch_we_in,
  input  wire logic [7:0]                 pch_wdata_in,
  input  wire logic                       gid_set_in,
  // core state
  output logic [ret_pkg::PC_W-1:0]        pc_out,
  output logic [7:0]                      working_register_out,
  output logic [7:0]                      pc_high_latch_out,
  output logic                            global_interrupt_disable_out,
  output logic                            forced_nop_out,
  output logic [ret_pkg::SP_W-1:0]        stack_depth_out
);
  logic rst_meta_q, rstn_q;  // reset release synchroniser

  // release reset through two flops so all logic leaves reset together
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_q <= 1'b0;
      rstn_q     <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rstn_q     <= rst_meta_q;
    end
  end

  stack_if stk ();
  ret_stack ret_stack_i (
    .clk  (clock_in),
    .rstn (rstn_q),
    .sp   (stk)
  );

  ret_pkg::phase_t            ph_q, ph_d;      // exec or forced nop
  logic [ret_pkg::PC_W-1:0]   pc_q, pc_d;      // program counter
  logic [7:0]                 work_q, work_d;  // working register
  logic [7:0]                 pch_q, pch_d;    // pc high latch
  logic                       gid_q, gid_d;    // global interrupt disable
  logic                       fnop_q, fnop_d;  // forced nop marker
  logic                       do_rfi, do_rlw;  // decoded returns

  // decode only in the exec phase; the prefetched word is ignored later
  assign do_rfi = instr_valid_in && (ph_q == ret_pkg::PH_EXEC)
                  && ret_pkg::is_retfi(instr_in);
  assign do_rlw = instr_valid_in && (ph_q == ret_pkg::PH_EXEC)
                  && ret_pkg::is_retlit(instr_in);

  // next state of the core registers
  always_comb begin
    ph_d          = ret_pkg::PH_EXEC;
    pc_d          = pc_q;
    work_d        = work_q;
    pch_d         = pch_q;
    gid_d         = gid_q;
    fnop_d        = 1'b0;
    stk.push      = 1'b0;
    stk.pop       = 1'b0;
    stk.push_data = pc_q + ret_pkg::PC_STEP;
    unique case (ph_q)
      ret_pkg::PH_EXEC: begin
        if (do_rfi) begin
          pc_d    = stk.top;
          stk.pop = 1'b1;
          gid_d   = 1'b0;
          ph_d    = ret_pkg::PH_FNOP;
        end else if (do_rlw) begin
          work_d  = instr_in[7:0];
          pc_d    = stk.top;
          stk.pop = 1'b1;
          ph_d    = ret_pkg::PH_FNOP;
        end else if (instr_valid_in && call_in) begin
          stk.push = 1'b1;
          pc_d     = call_addr_in;
        end else if (instr_valid_in) begin
          pc_d = pc_q + ret_pkg::PC_STEP;
        end
        // latch writes come only from explicit stores; returns never
        // touch it, so table lookups keep their page
        if (pch_we_in && !do_rlw && !do_rfi) begin
          pch_d = pch_wdata_in;
        end
        if (gid_set_in && !do_rfi) begin
          gid_d = 1'b1;
        end
      end
      ret_pkg::PH_FNOP: begin
        fnop_d = 1'b1;
      end
    endcase
  end

  // register stage
  always_ff @(posedge clock_in or negedge rstn_q) begin
    if (!rstn_q) begin
      ph_q   <= ret_pkg::PH_EXEC;
      pc_q   <= ret_pkg::PC_RST;
      work_q <= ret_pkg::WORK_RST;
      pch_q  <= ret_pkg::PCH_RST;
      gid_q  <= ret_pkg::GID_RST;
      fnop_q <= 1'b0;
    end else begin
      ph_q   <= ph_d;
      pc_q   <= pc_d;
      work_q <= work_d;
      pch_q  <= pch_d;
      gid_q  <= gid_d;
      fnop_q <= fnop_d;
    end
  end

  assign pc_out                       = pc_q;
  assign working_register_out         = work_q;
  assign pc_high_latch_out            = pch_q;
  assign global_interrupt_disable_out = gid_q;
  assign forced_nop_out               = fnop_q;
  assign stack_depth_out              = stk.depth;

  // checks
  property p_rfi_pc;
    @(posedge clock_in) disable iff (!rstn_q)
    do_rfi |=> (pc_q == $past(stk.top)) && !gid_q;
  endproperty
  a_rfi_pc: assert property (p_rfi_pc) else $error("rfi pc/gid");

  property p_rfi_pop;
    @(posedge clock_in) disable iff (!rstn_q)
    do_rfi |=> stk.depth == $past(stk.depth) - ret_pkg::SP_STEP;
  endproperty
  a_rfi_pop: assert property (p_rfi_pop) else $error("rfi pop");

  property p_rlw_w;
    @(posedge clock_in) disable iff (!rstn_q)
    do_rlw |=> work_q == $past(instr_in[7:0]);
  endproperty
  a_rlw_w: assert property (p_rlw_w) else $error("rlw work");

  property p_rlw_pc;
    @(posedge clock_in) disable iff (!rstn_q)
    do_rlw |=> pc_q == $past(stk.top)
      && stk.depth == $past(stk.depth) - ret_pkg::SP_STEP;
  endproperty
  a_rlw_pc: assert property (p_rlw_pc) else $error("rlw pc");

  property p_rlw_pch;
    @(posedge clock_in) disable iff (!rstn_q)
    do_rlw |=> $stable(pch_q);
  endproperty
  a_rlw_pch: assert property (p_rlw_pch) else $error("rlw pch");

  property p_fnop;
    @(posedge clock_in) disable iff (!rstn_q)
    (do_rfi || do_rlw) |=> ##1 fnop_q ##1 !fnop_q;
  endproperty
  a_fnop: assert property (p_fnop) else $error("forced nop");

  property p_fnop_hold;
    @(posedge clock_in) disable iff (!rstn_q)
    (ph_q == ret_pkg::PH_FNOP) |=> $stable(pc_q) && $stable(work_q);
  endproperty
  a_fnop_hold: assert property (p_fnop_hold) else $error("nop moved");

  property p_no_back;
    @(posedge clock_in) disable iff (!rstn_q)
    (do_rfi || do_rlw) |=> !(do_rfi || do_rlw);
  endproperty
  a_no_back: assert property (p_no_back) else $error("no spacing");

  c_rfi: cover property (@(posedge clock_in) do_rfi);
  c_rlw: cover property (@(posedge clock_in) do_rlw);
  c_call_ret: cover property (@(posedge clock_in)
    stk.push ##[1:8] do_rlw);
  // an unmasking return, and the marker after the discarded prefetch
  c_rfi_unmask: cover property (@(posedge clock_in) do_rfi && gid_q);
  c_fnop: cover property (@(posedge clock_in) fnop_q);

  // side effects the interrupt return must not have; a handler that relies on
  // the working register or the page latch surviving would break
  property p_rfi_work;
    @(posedge clock_in) disable iff (!rstn_q)
    do_rfi |=> $stable(work_q);
  endproperty
  a_rfi_work: assert property (p_rfi_work) else $error("rfi work");

  property p_rfi_pch;
    @(posedge clock_in) disable iff (!rstn_q)
    do_rfi |=> $stable(pch_q);
  endproperty
  a_rfi_pch: assert property (p_rfi_pch) else $error("rfi pch");

  // the nop cycle must not push, pop, write the latch or touch the mask
  property p_fnop_quiet;
    @(posedge clock_in) disable iff (!rstn_q)
    (ph_q == ret_pkg::PH_FNOP) |=> $stable(stk.depth) && $stable(pch_q)
      && $stable(gid_q);
  endproperty
  a_fnop_quiet: assert property (p_fnop_quiet) else $error("nop side");

  // the marker shows after the nop, when decode is live again
  property p_fnop_once;
    @(posedge clock_in) disable iff (!rstn_q)
    fnop_q |-> (ph_q == ret_pkg::PH_EXEC);
  endproperty
  a_fnop_once: assert property (p_fnop_once) else $error("nop phase");

  // only an explicit store outside a return moves the page latch
  property p_pch_write;
    @(posedge clock_in) disable iff (!rstn_q)
    (ph_q == ret_pkg::PH_EXEC) && pch_we_in && !do_rlw && !do_rfi
      |=> pch_q == $past(pch_wdata_in);
  endproperty
  a_pch_write: assert property (p_pch_write) else $error("pch store");
endmodule : return_instruction_exec

// file: stack_if.sv
// interface: push/pop port between the core and the return stack
`timescale 1ns/1ps
interface stack_if;
  logic                        push;  // store push_data, advance pointer
  logic                        pop;   // retreat pointer
  logic [ret_pkg::PC_W-1:0]    push_data;
  logic [ret_pkg::PC_W-1:0]    top;   // registered top-of-stack entry
  logic [ret_pkg::SP_W-1:0]    depth; // current pointer
  modport core  (output push, pop, push_data, input top, depth);
  modport stack (input push, pop, push_data, output top, depth);
endinterface : stack_if

// file: testbench.sv
// testbench: random and directed return, call and latch traffic with model
`timescale 1ns/1ps
module testbench;
  // design inputs
  logic        clock_in       = 1'b0;
  logic        rstn_in        = 1'b0;
  logic        instr_valid_in = 1'b0;
  logic [15:0] instr_in       = 16'h0000;
  logic        call_in        = 1'b0;
  logic [15:0] call_addr_in   = 16'h0000;
  logic        pch_we_in      = 1'b0;
  logic [7:0]  pch_wdata_in   = 8'h00;
  logic        gid_set_in     = 1'b0;
  // design outputs
  logic [15:0] pc_out;
  logic [7:0]  working_register_out;
  logic [7:0]  pc_high_latch_out;
  logic        global_interrupt_disable_out;
  logic        forced_nop_out;
  logic [3:0]  stack_depth_out;
  // reference model state, reset values as the design resets
  logic [15:0] stk [16];
  logic [15:0] m_pc   = 16'h0000;
  logic [7:0]  m_work = 8'h00;
  logic [7:0]  m_pch  = 8'h00;
  logic        m_gid  = 1'b1;
  logic        m_fnop = 1'b0;
  logic        m_nop  = 1'b0;
  logic [3:0]  m_sp   = 4'h0;
  integer      seed   = 99;
  integer      errors = 0;
  integer      n_tests = 0;
  integer      i;

  return_instruction_exec return_instruction_exec_i (
    .clock_in                     (clock_in),
    .rstn_in                      (rstn_in),
    .instr_valid_in               (instr_valid_in),
    .instr_in                     (instr_in),
    .call_in                      (call_in),
    .call_addr_in                 (call_addr_in),
    .pch_we_in                    (pch_we_in),
    .pch_wdata_in                 (pch_wdata_in),
    .gid_set_in                   (gid_set_in),
    .pc_out                       (pc_out),
    .working_register_out         (working_register_out),
    .pc_high_latch_out            (pc_high_latch_out),
    .global_interrupt_disable_out (global_interrupt_disable_out),
    .forced_nop_out               (forced_nop_out),
    .stack_depth_out              (stack_depth_out)
  );

  // 40 MHz core clock
  always #12.5 clock_in = ~clock_in;

  // one comparison, an unknown matches only an unknown
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // compare every core output against the model
  task automatic check_all();
    chk(pc_out, m_pc);
    chk({8'h00, working_register_out}, {8'h00, m_work});
    chk({8'h00, pc_high_latch_out}, {8'h00, m_pch});
    chk({15'h0, global_interrupt_disable_out}, {15'h0, m_gid});
    chk({15'h0, forced_nop_out}, {15'h0, m_fnop});
    chk({12'h0, stack_depth_out}, {12'h0, m_sp});
  endtask : check_all

  // drive one cycle, advance the model at the edge, compare just after
  task automatic step(input logic v, input logic [15:0] op, input logic c,
                      input logic [15:0] a, input logic w,
                      input logic [7:0] wd, input logic g);
    logic ret;
    logic rfi;
    instr_valid_in = v;
    instr_in       = op;
    call_in        = c;
    call_addr_in   = a;
    pch_we_in      = w;
    pch_wdata_in   = wd;
    gid_set_in     = g;
    @(posedge clock_in);
    rfi    = !m_nop && v && (op == ret_pkg::OPC_RETFI);
    ret    = rfi || (!m_nop && v && op[15:8] == ret_pkg::OPC_RETLIT_HI);
    m_fnop = m_nop;
    if (m_nop) begin
      m_nop = 1'b0;                     // prefetched word discarded
    end else begin
      if (ret) begin
        m_sp  = m_sp - 4'h1;
        m_pc  = stk[m_sp];
        m_nop = 1'b1;
        if (rfi) m_gid = 1'b0;
        else m_work = op[7:0];
      end else if (v && c) begin
        stk[m_sp] = m_pc + 16'h0001;
        m_sp      = m_sp + 4'h1;
        m_pc      = a;
      end else if (v) begin
        m_pc = m_pc + 16'h0001;         // plain instruction steps on
      end
      if (w && !ret) m_pch = wd;       // return wins over latch write
      if (g && !rfi) m_gid = 1'b1;
    end
    #1;
    check_all();
  endtask : step

  // verdict and end of run
  task automatic end_of_test();
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // a return followed by a garbage prefetch that must be ignored
  task automatic do_ret(input logic [15:0] op, input logic w,
                        input logic [7:0] wd, input logic g);
    step(1'b1, op, 1'b0, 16'h0000, w, wd, g);
    step(1'b1, 16'h0005, 1'b1, $random(seed), 1'b1, $random(seed), 1'b1);
  endtask : do_ret

  // main sequence
  initial begin
    repeat (6) @(posedge clock_in);
    #1;
    check_all();                        // values held in reset
    rstn_in = 1'b1;
    step(1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0, 8'h00, 1'b0);
    step(1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0, 8'h00, 1'b0);
    // directed: a return word without valid, then a plain instruction
    step(1'b0, 16'h0005, 1'b0, 16'h0000, 1'b0, 8'h00, 1'b0);
    step(1'b1, 16'h0000, 1'b0, 16'h0000, 1'b0, 8'h00, 1'b0);
    // directed: literal return with a coinciding latch write
    step(1'b1, 16'h0000, 1'b1, 16'h1234, 1'b1, 8'h5a, 1'b0);
    do_ret(16'hb6a5, 1'b1, 8'hc3, 1'b0);
    // directed: interrupt return with a coinciding disable request
    step(1'b1, 16'h0000, 1'b1, 16'hfffe, 1'b0, 8'h00, 1'b1);
    do_ret(16'h0005, 1'b0, 8'h00, 1'b1);
    // random mix kept inside the documented stack depth
    for (i = 0; i < 300; i = i + 1) begin
      if (m_sp == 4'h0 || (m_sp < 4'hf && $random(seed) % 2 == 0))
        step(1'b1, 16'h0000, ($random(seed) % 4 != 0), $random(seed),
             $random(seed),
             $random(seed), $random(seed));
      else if ($random(seed) % 2 == 0)
        do_ret({8'hb6, 8'($random(seed))}, $random(seed), $random(seed),
               $random(seed));
      else
        do_ret(16'h0005, $random(seed), $random(seed), $random(seed));
    end
    end_of_test();
  end
endmodule : testbench
